//--- hw/fidsec_sync.sv
// fidsec_sync: three-stage pin synchroniser with change-on-agreement
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module fidsec_sync
  import fidsec_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic [SYNC_STAGES-1:0] stage;
  // reset to the pin's idle level so no false edge follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {SYNC_STAGES{RST_VAL}};
    end else if (ce) begin
      stage <= {stage[SYNC_STAGES-2:0], din};
    end
  end
  // change counted once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dout <= RST_VAL;
    end else if (ce) begin
      if (stage[1] == stage[2]) begin
        dout <= stage[2];
      end
    end
  end
endmodule

//--- hw/fidsec_top.sv
// fidsec_top: id read, secured region mode and security register commands
// assumes serial clock well below clk_sys/8; mode 0 on a single data line
// Behaviour
// R1: id read is opcode, two dummy bytes, one address byte, select low
// R2: id bytes shift out on falling serial clock, msb first
// R3: address zero gives maker code then device code
// R4: address one gives device code then maker code
// R5: id bytes alternate while selected; select rising ends command
// R6: enter command sets secured mode, blocking main array access
// R7: in secured mode reads and programs target the secured region
// R8: enter command is a lone opcode; upper io lines ignored
// R9: in secured mode status write, lock write and all wipes rejected
// R10: once locked, only read commands accepted for the secured region
// R11: exit command, lone opcode, returns to main array access
// R12: security read drives register value until select rises
// R13: security read accepted any time, repeated while clocked
// R14: bit 0 is read-only factory lock indicator
// R15: bit 1 set only by lock write; then bit and region frozen
// R16: bit 2 set on program suspend, cleared on resume, default 0
// R17: bit 3 set on erase suspend, cleared on resume, default 0
// R18: bit 5 set by failed program, cleared by next successful one
// R19: bit 6 set by failed erase, cleared by next successful one
// R20: host must send write enable before lock write
// R21: dummy byte contents of id read are ignored
`timescale 1ns/1ps
module fidsec_top
  import fidsec_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = MAKER_CODE_DFLT,
  parameter logic [7:0] DEVICE_CODE = DEVICE_CODE_DFLT
) (
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  input  wire logic      ce,
  input  wire logic      chip_select_n,
  input  wire logic      serial_clock,
  input  wire logic      serial_input_line,
  input  wire logic [2:0] upper_io_lines,
  output logic           serial_output_line,
  output logic           serial_output_oe,
  input  wire logic      factory_locked,
  input  wire logic      lock_nv_in,
  input  wire fidsec_core_ev_s core_ev,
  output logic           lock_nv_write,
  output fidsec_cmd_s    cmd_out,
  output logic [7:0]     security_status
);
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_OPCODE = 5'b00010,
    ST_ID_PRE = 5'b00100,
    ST_SHIFT  = 5'b01000,
    ST_IGNORE = 5'b10000
  } fidsec_state_e;

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  fidsec_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (chip_select_n),
    .dout    (cs_n_s)
  );
  fidsec_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (serial_clock),
    .dout    (sck_s)
  );
  fidsec_sync #(.RST_VAL(1'b0)) u_sync_si (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (serial_input_line),
    .dout    (si_s)
  );

  logic sck_d;
  logic cs_d;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else if (ce) begin
      sck_d <= sck_s;
      cs_d  <= cs_n_s;
    end
  end
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  assign sck_rise = ce && !cs_n_s && sck_s && !sck_d;
  assign sck_fall = ce && !cs_n_s && !sck_s && sck_d;
  assign cs_rise  = ce && cs_n_s && !cs_d;
  assign cs_fall  = ce && !cs_n_s && cs_d;

  fidsec_state_e state;
  logic [2:0]    bit_cnt;
  logic [1:0]    pre_cnt;
  logic [7:0]    shreg;
  logic [7:0]    next_byte;
  logic [7:0]    opcode;
  logic          op_is_id;
  logic          toggle_sel;
  logic          wel;
  logic          otp_mode;
  logic          lock_bit;
  logic          psusp;
  logic          esusp;
  logic          pfail;
  logic          efail;
  logic [7:0]    out_byte;
  logic [7:0]    sec_reg;
  logic          byte_done;

  assign byte_done = sck_rise && (bit_cnt == BIT_LAST);
  assign next_byte = {shreg[6:0], si_s};

  // upper io lines are don't care on every command here
  logic unused_io;
  assign unused_io = ^upper_io_lines; // [R8]

  function automatic logic is_wipe_or_write(input logic [7:0] op);
    return op == OP_WRITE_STATUS || op == OP_WRITE_SEC || op == OP_CHIP_WIPE_A
        || op == OP_CHIP_WIPE_B || op == OP_BLOCK_WIPE || op == OP_SMALL_WIPE
        || op == OP_HALF_WIPE;
  endfunction
  function automatic logic is_read(input logic [7:0] op);
    return op == OP_READ || op == OP_FAST_READ;
  endfunction

  always_comb begin
    sec_reg = '0;
    sec_reg[SEC_FACTORY_BIT] = factory_locked; // [R14]
    sec_reg[SEC_LOCK_BIT]    = lock_bit;
    sec_reg[SEC_PSUSP_BIT]   = psusp;
    sec_reg[SEC_ESUSP_BIT]   = esusp;
    sec_reg[SEC_PFAIL_BIT]   = pfail;
    sec_reg[SEC_EFAIL_BIT]   = efail;
  end
  assign security_status = sec_reg;

  // serial command sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      bit_cnt    <= '0;
      pre_cnt    <= '0;
      shreg      <= '0;
      opcode     <= '0;
      op_is_id   <= 1'b0;
      toggle_sel <= 1'b0;
      out_byte   <= '0;
    end else if (cs_rise) begin
      state <= ST_IDLE; // [R5] [R12]
    end else if (cs_fall) begin
      state   <= ST_OPCODE;
      bit_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (ce) begin
            bit_cnt <= '0;
          end
        end
        ST_OPCODE: begin
          if (sck_rise) begin
            shreg   <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
          end
          if (byte_done) begin
            opcode <= next_byte;
            if (next_byte == OP_READ_ID) begin
              state   <= ST_ID_PRE; // [R1]
              pre_cnt <= '0;
            end else if (next_byte == OP_READ_SEC) begin
              state    <= ST_SHIFT; // [R13]
              op_is_id <= 1'b0;
              out_byte <= sec_reg;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ID_PRE: begin
          if (sck_rise) begin
            shreg   <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
          end
          if (byte_done) begin
            pre_cnt <= pre_cnt + 2'h1;
            // dummy bytes only counted, their value never read [R21]
            if (pre_cnt == ID_PRE_BYTES - 2'h1) begin
              state    <= ST_SHIFT;
              op_is_id <= 1'b1;
              if (next_byte == ADDR_DEVICE_FIRST) begin
                out_byte   <= DEVICE_CODE; // [R4]
                toggle_sel <= 1'b0;
              end else begin
                out_byte   <= MAKER_CODE; // [R3]
                toggle_sel <= 1'b1;
              end
            end
          end
        end
        ST_SHIFT: begin
          if (sck_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              if (op_is_id) begin
                out_byte   <= toggle_sel ? DEVICE_CODE : MAKER_CODE; // [R5]
                toggle_sel <= !toggle_sel;
              end else begin
                out_byte <= sec_reg; // [R13]
              end
            end
          end
        end
        ST_IGNORE: begin
          if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
      endcase
    end
  end

  // output bit: msb first, changes on falling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_output_line <= 1'b0;
      serial_output_oe   <= 1'b0;
    end else if (ce) begin
      if (cs_n_s || state != ST_SHIFT) begin
        serial_output_oe <= 1'b0;
      end else if (sck_fall) begin
        serial_output_oe   <= 1'b1; // [R12]
        serial_output_line <= out_byte[BIT_LAST - bit_cnt]; // [R2]
      end
    end
  end

  // lone-opcode commands take effect at select rising on a byte boundary
  logic lone_ok;
  assign lone_ok = cs_rise && state == ST_IGNORE && bit_cnt == '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otp_mode <= 1'b0;
    end else if (lone_ok && opcode == OP_ENTER_OTP) begin
      otp_mode <= 1'b1; // [R6] [R8]
    end else if (lone_ok && opcode == OP_EXIT_OTP) begin
      otp_mode <= 1'b0; // [R11]
    end
  end

  logic sec_write_ok;
  assign sec_write_ok = lone_ok && opcode == OP_WRITE_SEC && wel && !otp_mode // [R9]
                        && !lock_bit;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wel <= 1'b0;
    end else if (lone_ok && opcode == OP_WRITE_ENABLE) begin
      wel <= 1'b1; // [R20]
    end else if (lone_ok && opcode == OP_WRITE_SEC) begin
      wel <= 1'b0;
    end
  end

  // lock bit loaded from non-volatile store after reset, set-only
  logic lock_loaded;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_bit    <= 1'b0;
      lock_loaded <= 1'b0;
    end else if (ce) begin
      lock_loaded <= 1'b1;
      if (!lock_loaded) begin
        lock_bit <= lock_nv_in;
      end else if (sec_write_ok) begin
        lock_bit <= 1'b1; // [R15]
      end
    end
  end
  assign lock_nv_write = sec_write_ok;

  // suspend and failure flags; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psusp <= 1'b0;
      esusp <= 1'b0;
      pfail <= 1'b0;
      efail <= 1'b0;
    end else if (ce) begin
      if (core_ev.program_suspended) begin
        psusp <= 1'b1; // [R16]
      end else if (core_ev.program_resumed) begin
        psusp <= 1'b0;
      end
      if (core_ev.erase_suspended) begin
        esusp <= 1'b1; // [R17]
      end else if (core_ev.erase_resumed) begin
        esusp <= 1'b0;
      end
      if (core_ev.program_failed) begin
        pfail <= 1'b1; // [R18]
      end else if (core_ev.program_passed) begin
        pfail <= 1'b0;
      end
      if (core_ev.erase_failed) begin
        efail <= 1'b1; // [R19]
      end else if (core_ev.erase_passed) begin
        efail <= 1'b0;
      end
    end
  end

  // command verdict for the array core
  logic op_done;
  logic reject;
  assign op_done = ce && state == ST_OPCODE && byte_done;
  always_comb begin
    reject = 1'b0;
    if (otp_mode && is_wipe_or_write(next_byte)) begin
      reject = 1'b1; // [R9]
    end else if (otp_mode && (lock_bit || factory_locked) && !is_read(next_byte)
                 && next_byte != OP_READ_SEC && next_byte != OP_EXIT_OTP
                 && next_byte != OP_READ_ID) begin
      reject = 1'b1; // [R10]
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= '0;
    end else if (ce) begin
      cmd_out.otp_mode      <= otp_mode;
      cmd_out.array_blocked <= otp_mode; // [R6]
      cmd_out.route_to_otp  <= otp_mode && (is_read(opcode) || opcode == OP_PROGRAM); // [R7]
      cmd_out.accepted      <= op_done && !reject;
      cmd_out.reject        <= op_done && reject;
      if (op_done) begin
        cmd_out.accepted_op <= next_byte;
      end
    end
  end
endmodule

//--- shared/fidsec_pkg.sv
// fidsec_pkg: opcodes, security register layout, id values, sync depth
// assumes single-lane serial bus, mode 0 (sample on rising, shift on falling)
package fidsec_pkg;
  localparam logic [7:0] OP_READ_ID        = 8'h90;
  localparam logic [7:0] OP_ENTER_OTP      = 8'hB1;
  localparam logic [7:0] OP_EXIT_OTP       = 8'hC1;
  localparam logic [7:0] OP_READ_SEC       = 8'h2B;
  localparam logic [7:0] OP_WRITE_SEC      = 8'h2F;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
  localparam logic [7:0] OP_CHIP_WIPE_A    = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B    = 8'hC7;
  localparam logic [7:0] OP_BLOCK_WIPE     = 8'hD8;
  localparam logic [7:0] OP_SMALL_WIPE     = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE      = 8'h52;
  localparam logic [7:0] OP_READ           = 8'h03;
  localparam logic [7:0] OP_FAST_READ      = 8'h0B;
  localparam logic [7:0] OP_PROGRAM        = 8'h02;
  // arbitrary neutral identity values
  localparam logic [7:0] MAKER_CODE_DFLT   = 8'h5A;
  localparam logic [7:0] DEVICE_CODE_DFLT  = 8'h3C;
  localparam logic [7:0] ADDR_MAKER_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_FIRST = 8'h01;
  localparam int         SEC_FACTORY_BIT   = 0;
  localparam int         SEC_LOCK_BIT      = 1;
  localparam int         SEC_PSUSP_BIT     = 2;
  localparam int         SEC_ESUSP_BIT     = 3;
  localparam int         SEC_PFAIL_BIT     = 5;
  localparam int         SEC_EFAIL_BIT     = 6;
  localparam logic [2:0] BIT_LAST          = 3'h7;
  localparam logic [1:0] ID_PRE_BYTES      = 2'h3;
  localparam int         SYNC_STAGES       = 3;
  typedef struct packed {
    logic program_suspended;
    logic program_resumed;
    logic erase_suspended;
    logic erase_resumed;
    logic program_failed;
    logic program_passed;
    logic erase_failed;
    logic erase_passed;
  } fidsec_core_ev_s;
  typedef struct packed {
    logic otp_mode;
    logic array_blocked;
    logic route_to_otp;
    logic reject;
    logic [7:0] accepted_op;
    logic accepted;
  } fidsec_cmd_s;
endpackage

//--- sim/fidsec_host_model.sv
// fidsec_host_model: host side of the serial bus, mode 0, one data line
// assumes the bench calls its tasks; serial clock still outside frames
`timescale 1ns/1ps
module fidsec_host_model (
  output logic       chip_select_n,
  output logic       serial_clock,
  output logic       serial_input_line,
  output logic [2:0] upper_io_lines,
  input  wire logic  serial_output_line
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_input_line = 1'b0;
    upper_io_lines = 3'h5;
  end
  task automatic open_frame();
    chip_select_n = 1'b0;
    #100;
  endtask
  task automatic close_frame();
    #100;
    chip_select_n = 1'b1;
    #300;
  endtask
  // msb first, data set while clock low
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_input_line = tx[i];
      upper_io_lines = ~upper_io_lines;
      #62.5 serial_clock = 1'b1;
      rx[i] = serial_output_line;
      #62.5 serial_clock = 1'b0;
    end
    serial_input_line = ~serial_input_line;
  endtask
  // select rises at the byte boundary
  task automatic lone_op(input logic [7:0] op);
    logic [7:0] rx;
    open_frame();
    shift_byte(op, rx);
    close_frame();
  endtask
endmodule

//--- sim/fidsec_top_props.sv
// fidsec_top_props: port-level checks for fidsec_top
// assumes one clk_sys domain; bound to every fidsec_top instance
`timescale 1ns/1ps
module fidsec_top_props
  import fidsec_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic            ce,
  input wire logic            chip_select_n,
  input wire logic            factory_locked,
  input wire fidsec_core_ev_s core_ev,
  input wire logic            serial_output_oe,
  input wire logic            lock_nv_write,
  input wire fidsec_cmd_s     cmd_out,
  input wire logic [7:0]      security_status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence cs_idle;
    chip_select_n [*8];
  endsequence
  sequence fact_steady;
    $stable(factory_locked) [*2];
  endsequence
  oe_release_a: assert property (cs_idle |-> !serial_output_oe)
    else $error("output enabled while deselected");
  fact_view_a: assert property (fact_steady |-> security_status[0] == factory_locked)
    else $error("factory bit wrong");
  psusp_set_a: assert property (ce && core_ev.program_suspended |=> security_status[2])
    else $error("program suspend bit not set");
  psusp_clr_a: assert property (ce && core_ev.program_resumed && !core_ev.program_suspended
    |=> !security_status[2]) else $error("program suspend bit not cleared");
  esusp_set_a: assert property (ce && core_ev.erase_suspended |=> security_status[3])
    else $error("erase suspend bit not set");
  pfail_set_a: assert property (ce && core_ev.program_failed |=> security_status[5])
    else $error("program fail bit not set");
  pfail_clr_a: assert property (ce && core_ev.program_passed && !core_ev.program_failed
    |=> !security_status[5]) else $error("program fail bit not cleared");
  efail_set_a: assert property (ce && core_ev.erase_failed |=> security_status[6])
    else $error("erase fail bit not set");
  lock_gate_a: assert property (lock_nv_write |-> !cmd_out.otp_mode && !security_status[1])
    else $error("lock write not refused");
  lock_keep_a: assert property (security_status[1] |=> security_status[1])
    else $error("lock bit cleared");
  otp_block_a: assert property (cmd_out.otp_mode |-> cmd_out.array_blocked)
    else $error("array open in secured mode");
endmodule
bind fidsec_top fidsec_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
  .chip_select_n(chip_select_n), .factory_locked(factory_locked), .core_ev(core_ev),
  .serial_output_oe(serial_output_oe), .lock_nv_write(lock_nv_write), .cmd_out(cmd_out),
  .security_status(security_status));

//--- sim/tb_top.sv
// tb_top: bench for fidsec_top driven through the host model
// assumes 100 MHz clk_sys and a 125 ns serial clock
`timescale 1ns/1ps
module tb_top
  import fidsec_pkg::*;
;
  logic            clk_sys;
  logic            rst_n;
  logic            factory_locked;
  logic            lock_nv_in;
  fidsec_core_ev_s core_ev;
  logic            cs_n;
  logic            sck;
  logic            si;
  logic [2:0]      upper_io;
  logic            so;
  logic            nv_wr;
  fidsec_cmd_s     cmd;
  logic [7:0]      sec;
  logic            rej_seen;
  logic            wr_seen;
  logic            ce;
  logic            oe;
  int              fail_count;
  int              checks;
  fidsec_host_model u_host (.chip_select_n(cs_n), .serial_clock(sck),
    .serial_input_line(si), .upper_io_lines(upper_io), .serial_output_line(so));
  fidsec_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .chip_select_n(cs_n),
    .serial_clock(sck), .serial_input_line(si), .upper_io_lines(upper_io),
    .serial_output_line(so), .serial_output_oe(oe), .factory_locked(factory_locked),
    .lock_nv_in(lock_nv_in), .core_ev(core_ev), .lock_nv_write(nv_wr), .cmd_out(cmd),
    .security_status(sec));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // sticky flags and lock store
  always @(posedge clk_sys) begin
    if (cmd.reject) rej_seen <= 1'b1;
    if (nv_wr) begin
      wr_seen <= 1'b1;
      lock_nv_in <= 1'b1;
    end
  end
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_byte(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic pulse(input logic [7:0] ev);
    @(posedge clk_sys) #1 core_ev = fidsec_core_ev_s'(ev);
    @(posedge clk_sys) #1 core_ev = '0;
    @(posedge clk_sys) #1;
  endtask
  task automatic t_ident(input logic [7:0] adr, input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] rx;
    u_host.open_frame();
    u_host.shift_byte(OP_READ_ID, rx);
    u_host.shift_byte(8'hFF, rx);
    u_host.shift_byte(8'hA5, rx);
    u_host.shift_byte(adr, rx);
    for (int k = 0; k < 4; k++) begin
      u_host.shift_byte(8'h55, rx);
      cmp_byte("id byte", k[0] ? b1 : b0, rx);
    end
    cmp_bit("oe driving", 1'b1, oe);
    u_host.close_frame();
    cmp_bit("oe released", 1'b0, oe);
    $display("id read %h done", adr);
  endtask
  task automatic t_sec_read(input logic [7:0] exp);
    logic [7:0] rx;
    u_host.open_frame();
    u_host.shift_byte(OP_READ_SEC, rx);
    for (int k = 0; k < 3; k++) begin
      u_host.shift_byte(8'h55, rx);
      cmp_byte("security read", exp, rx & 8'h6F);
    end
    u_host.close_frame();
  endtask
  task automatic t_events();
    @(posedge clk_sys) #1 ce = 1'b0;
    pulse(8'h80);
    cmp_bit("frozen suspend", 1'b0, sec[SEC_PSUSP_BIT]);
    ce = 1'b1;
    @(posedge clk_sys) #1 factory_locked = 1'b1;
    pulse(8'h80);
    pulse(8'h20);
    pulse(8'h08);
    pulse(8'h02);
    pulse(8'h0C);
    cmp_byte("status", 8'h6D, sec & 8'h6F);
    t_sec_read(8'h6D);
    pulse(8'h40);
    pulse(8'h10);
    pulse(8'h04);
    pulse(8'h01);
    @(posedge clk_sys) #1 factory_locked = 1'b0;
    #20;
    cmp_byte("status", 8'h00, sec & 8'h6F);
    t_sec_read(8'h00);
    $display("event test done");
  endtask
  task automatic t_otp();
    logic [7:0] ops [7] = '{OP_WRITE_STATUS, OP_WRITE_SEC, OP_CHIP_WIPE_A, OP_CHIP_WIPE_B,
      OP_BLOCK_WIPE, OP_SMALL_WIPE, OP_HALF_WIPE};
    wr_seen = 1'b0;
    u_host.lone_op(OP_WRITE_SEC);
    cmp_bit("write without enable", 1'b0, wr_seen);
    u_host.lone_op(OP_ENTER_OTP);
    cmp_bit("otp mode", 1'b1, cmd.otp_mode);
    cmp_bit("array blocked", 1'b1, cmd.array_blocked);
    u_host.lone_op(OP_READ);
    cmp_bit("route to otp", 1'b1, cmd.route_to_otp);
    cmp_byte("accepted op", OP_READ, cmd.accepted_op);
    for (int k = 0; k < 7; k++) begin
      u_host.lone_op(OP_WRITE_ENABLE);
      rej_seen = 1'b0;
      u_host.lone_op(ops[k]);
      cmp_bit("reject", 1'b1, rej_seen);
    end
    cmp_bit("lock write in otp", 1'b0, wr_seen);
    u_host.lone_op(OP_EXIT_OTP);
    cmp_bit("otp mode", 1'b0, cmd.otp_mode);
    u_host.lone_op(OP_READ);
    cmp_bit("route to array", 1'b0, cmd.route_to_otp);
    $display("otp test done");
  endtask
  task automatic t_lock();
    u_host.lone_op(OP_WRITE_ENABLE);
    u_host.lone_op(OP_WRITE_SEC);
    cmp_bit("lock write", 1'b1, wr_seen);
    cmp_bit("lock bit", 1'b1, sec[SEC_LOCK_BIT]);
    wr_seen = 1'b0;
    u_host.lone_op(OP_WRITE_ENABLE);
    u_host.lone_op(OP_WRITE_SEC);
    cmp_bit("second lock write", 1'b0, wr_seen);
    u_host.lone_op(OP_ENTER_OTP);
    rej_seen = 1'b0;
    u_host.lone_op(OP_PROGRAM);
    cmp_bit("locked program", 1'b1, rej_seen);
    u_host.lone_op(OP_EXIT_OTP);
    $display("lock test done");
  endtask
  initial begin
    #500000;
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    factory_locked = 1'b0;
    lock_nv_in = 1'b0;
    core_ev = '0;
    rej_seen = 1'b0;
    wr_seen = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    t_ident(ADDR_MAKER_FIRST, MAKER_CODE_DFLT, DEVICE_CODE_DFLT);
    t_ident(ADDR_DEVICE_FIRST, DEVICE_CODE_DFLT, MAKER_CODE_DFLT);
    t_ident(8'h02, MAKER_CODE_DFLT, DEVICE_CODE_DFLT);
    t_events();
    t_otp();
    t_lock();
    end_sim();
  end
endmodule
